// File: inc/ssrc_pkg.sv
/*
 shared constants for the sensor standby / reset control pair.
 assumes one 10 MHz clock (aclk) for both ends.
*/
package ssrc_pkg;
  // ****************************************
  // sensor register map
  // ****************************************
  localparam logic [7:0]  SCR_ADDR    = 8'h0D;
  localparam logic [7:0]  CPC_ADDR    = 8'h65;
  localparam logic [15:0] SCR_RESET   = 16'h0000;
  localparam logic [15:0] CPC_RESET   = 16'h2000;
  localparam int          SCR_SRST    = 0;
  localparam int          SCR_RESTART = 1;
  localparam int          SCR_SWSTBY  = 2;
  localparam int          SCR_OUTDIS  = 4;
  localparam int          SCR_DRIVE   = 6;
  localparam int          SCR_PINDIS  = 7;
  localparam int          CPC_PLLPD   = 13;
  localparam int          CPC_BYPASS  = 15;
  localparam int          N_DOM       = 4;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_HZ        = 10000000;
  localparam int PIN_SYNC      = 2;
  localparam int RST_READY_CYC = 3;
  localparam int STOP_WAIT_CYC = 2;
  localparam int WAKE_CLK_CYC  = 1;
  localparam int WAKE_ANA_CYC  = 1;
  localparam int HOST_WAIT_CYC = PIN_SYNC + RST_READY_CYC + 1;
  // ****************************************
  // host register map (axi4-lite byte offsets)
  // ****************************************
  localparam logic [3:0] H_CTRL   = 4'h0;
  localparam logic [3:0] H_ACC    = 4'h4;
  localparam logic [3:0] H_STAT   = 4'h8;
  localparam int         C_STBY   = 0;
  localparam int         C_HRST   = 1;
  localparam int         C_CLKON  = 2;
  localparam int         C_AUTO   = 3;
  localparam int         A_GO     = 31;
  localparam int         A_WE     = 30;
  localparam logic [3:0] CTRL_RST = 4'h6;
endpackage : ssrc_pkg

// File: inc/ssrc_if.sv
/*
 pins between host controller and sensor control logic.
 assumes the bench ties both ends to one aclk; pins_oe replaces tristate.
*/
`timescale 1ns/1ps
interface ssrc_if;
  logic        standby_pin;
  logic        reset_pin_n;
  logic        clk_run;
  logic        req;
  logic        we;
  logic [7:0]  addr;
  logic [15:0] wdata;
  logic        ack;
  logic [15:0] rdata;
  logic        line_valid;
  logic        frame_valid;
  logic        pixel_clock_out;
  logic        flash_strobe;
  logic [9:0]  pixel_bus;
  logic        pins_oe;
  modport dev  (input standby_pin, reset_pin_n, clk_run, req, we, addr, wdata,
                output ack, rdata, line_valid, frame_valid, pixel_clock_out,
                flash_strobe, pixel_bus, pins_oe);
  modport host (output standby_pin, reset_pin_n, clk_run, req, we, addr, wdata,
                input ack, rdata, line_valid, frame_valid, pixel_clock_out,
                flash_strobe, pixel_bus, pins_oe);
endinterface : ssrc_if

// File: rtl/ssrc_dev.sv
/*
 sensor end: standby entry/exit, clock gating, hard and soft reset.
 assumes host keeps its side of the pin protocol; clk_run low models
 a stopped input clock.
*/
// Decided for this implementation: register access over AXI4-Lite and the register addresses.
// Function
// - standby pin enters standby unless masked
// - software standby bit enters standby too
// - request latched; entry always completes
// - finish row, gate clocks, analog off
// - stay in standby while source asserted
// - video outputs forced low in standby
// - registers kept, serial access in standby
// - no serial answers while clock stopped
// - host exits via same source used
// - wake clocks, analog, then timing restart
// - host restarts clock before leaving standby
// - pll powers down if enable bit set
// - host sets pll bypass before standby
// - domains clocked on need, overridable
// - serial access logic always clocked
// - host asserts hard reset after power-up
// - reset pin low enters reset, clockless
// - serial ready three clocks after release
// - soft reset bit restores all defaults
// - clearing soft reset resumes at once
// - host waits valids low plus two
`timescale 1ns/1ps
module ssrc_dev
  import ssrc_pkg::*;
#(
  parameter int ROW_LEN   = 16,
  parameter int LINE_TOT  = 24,
  parameter int FRAME_ROW = 8,
  parameter int FRAME_TOT = 10
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  ssrc_if.dev              dev,
  output      logic        analog_on,
  output      logic        pll_on,
  output      logic        clocks_gated,
  output      logic [N_DOM-1:0] domain_clk_en,
  output      logic        serial_ready
);
  // ****************************************
  // state
  // ****************************************
  typedef enum logic [2:0] {
    ST_RUN, ST_FINISH, ST_GATED, ST_WAKE_CLK, ST_WAKE_ANA
  } ssrc_st_type;

  localparam int CW = $clog2(LINE_TOT);
  localparam int RW = $clog2(FRAME_TOT);

  typedef struct packed {
    logic [PIN_SYNC-1:0] syn_rst;
    logic [PIN_SYNC-1:0] syn_stby;
    logic [1:0]          rdy_cnt;
    logic                ready;
    ssrc_st_type         st;
    logic                src_pin;
    logic [1:0]          wcnt;
    logic [15:0]         scr;
    logic [15:0]         cpc;
    logic [CW-1:0]       col;
    logic [RW-1:0]       row;
    logic                lv;
    logic                fv;
    logic                pclk;
    logic                flash;
    logic [9:0]          pix;
    logic                oe;
    logic                ack;
    logic [15:0]         rdata;
    logic                ana;
    logic                pll;
    logic                gated;
    logic [N_DOM-1:0]    dom;
  } ssrc_dev_type;

  ssrc_dev_type s_r;
  ssrc_dev_type s_nxt;

  function automatic ssrc_dev_type ssrc_init();
    ssrc_dev_type v;
    v       = '0;
    v.st    = ST_RUN;
    v.scr   = SCR_RESET;
    v.cpc   = CPC_RESET;
    v.ana   = 1'b1;
    v.pll   = 1'b1;
    v.oe    = 1'b1;
    return v;
  endfunction : ssrc_init

  logic pin_req;
  logic sw_req;
  logic hold;
  logic active;

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_nxt          = s_r;
    pin_req        = s_r.syn_stby[PIN_SYNC-1] & ~s_r.scr[SCR_PINDIS];
    sw_req         = s_r.scr[SCR_SWSTBY];
    hold           = s_r.src_pin ? pin_req : sw_req;
    active         = 1'b0;
    s_nxt.ack      = 1'b0;
    s_nxt.syn_rst  = {s_r.syn_rst[PIN_SYNC-2:0], dev.reset_pin_n};
    s_nxt.syn_stby = {s_r.syn_stby[PIN_SYNC-2:0], dev.standby_pin};
    if (!s_r.syn_rst[PIN_SYNC-1]) begin
      // reset pin acts whether the input clock runs or not
      s_nxt          = ssrc_init();
      s_nxt.syn_rst  = {s_r.syn_rst[PIN_SYNC-2:0], dev.reset_pin_n};
      s_nxt.syn_stby = {s_r.syn_stby[PIN_SYNC-2:0], dev.standby_pin};
    end else if (dev.clk_run) begin
      if (!s_r.ready) begin
        if (s_r.rdy_cnt == 2'(RST_READY_CYC - 1)) begin
          s_nxt.ready = 1'b1;
        end else begin
          s_nxt.rdy_cnt = s_r.rdy_cnt + 2'd1;
        end
      end
      // serial access path stays clocked in every state
      if (s_r.ready && dev.req && !s_r.ack) begin
        s_nxt.ack   = 1'b1;
        s_nxt.rdata = '0;
        if (dev.addr == SCR_ADDR) begin
          s_nxt.rdata = s_r.scr;
        end else if (dev.addr == CPC_ADDR) begin
          s_nxt.rdata = s_r.cpc;
        end
        if (dev.we && dev.addr == SCR_ADDR) begin
          if (dev.wdata[SCR_SRST]) begin
            s_nxt               = ssrc_init();
            s_nxt.syn_rst       = {s_r.syn_rst[PIN_SYNC-2:0], dev.reset_pin_n};
            s_nxt.syn_stby      = {s_r.syn_stby[PIN_SYNC-2:0], dev.standby_pin};
            s_nxt.ready         = 1'b1;
            s_nxt.ack           = 1'b1;
            s_nxt.scr[SCR_SRST] = 1'b1;
          end else begin
            s_nxt.scr              = dev.wdata;
            s_nxt.scr[SCR_RESTART] = 1'b0;
            if (dev.wdata[SCR_RESTART]) begin
              s_nxt.col = '0;
              s_nxt.row = '0;
            end
          end
        end else if (dev.we && dev.addr == CPC_ADDR) begin
          s_nxt.cpc = dev.wdata;
        end
      end
      if (!s_r.scr[SCR_SRST]) begin
        case (s_r.st)
          ST_RUN: begin
            active = 1'b1;
            if (pin_req | sw_req) begin
              s_nxt.src_pin = pin_req;
              s_nxt.st      = ST_FINISH;
            end
          end
          ST_FINISH: begin
            // request may drop here; entry still completes
            if (s_r.col >= CW'(ROW_LEN)) begin
              s_nxt.st    = ST_GATED;
              s_nxt.gated = 1'b1;
              s_nxt.ana   = 1'b0;
              s_nxt.pll   = ~s_r.cpc[CPC_PLLPD];
            end else begin
              active = 1'b1;
            end
          end
          ST_GATED: begin
            if (!hold) begin
              s_nxt.st    = ST_WAKE_CLK;
              s_nxt.gated = 1'b0;
              s_nxt.wcnt  = '0;
            end
          end
          ST_WAKE_CLK: begin
            s_nxt.wcnt = s_r.wcnt + 2'd1;
            if (s_r.wcnt == 2'(WAKE_CLK_CYC - 1)) begin
              s_nxt.st   = ST_WAKE_ANA;
              s_nxt.ana  = 1'b1;
              s_nxt.pll  = 1'b1;
              s_nxt.wcnt = '0;
            end
          end
          ST_WAKE_ANA: begin
            s_nxt.wcnt = s_r.wcnt + 2'd1;
            if (s_r.wcnt == 2'(WAKE_ANA_CYC - 1)) begin
              s_nxt.st  = ST_RUN;
              s_nxt.col = '0;
              s_nxt.row = '0;
            end
          end
          default: begin
            s_nxt.st = ST_RUN;
          end
        endcase
      end
      if (active) begin
        if (s_r.col == CW'(LINE_TOT - 1)) begin
          s_nxt.col = '0;
          s_nxt.row = (s_r.row == RW'(FRAME_TOT - 1)) ? '0 : s_r.row + 1'b1;
        end else begin
          s_nxt.col = s_r.col + 1'b1;
        end
      end
      s_nxt.fv    = active & (s_nxt.row < RW'(FRAME_ROW));
      s_nxt.lv    = s_nxt.fv & (s_nxt.col < CW'(ROW_LEN));
      s_nxt.pix   = s_nxt.lv ? 10'(s_nxt.col) : '0;
      s_nxt.flash = s_nxt.fv & (s_nxt.row == '0);
      s_nxt.pclk  = active & ~s_r.pclk;
      // drive_pins keeps pins driven; no gain from high-z while asleep
      s_nxt.oe    = ~s_nxt.scr[SCR_OUTDIS] &
                    (~(s_nxt.st == ST_GATED) | s_nxt.scr[SCR_DRIVE]);
      s_nxt.dom   = s_nxt.cpc[N_DOM-1:0] | {N_DOM{active}};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r <= ssrc_init();
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign dev.ack             = s_r.ack;
  assign dev.rdata           = s_r.rdata;
  assign dev.line_valid      = s_r.lv;
  assign dev.frame_valid     = s_r.fv;
  assign dev.pixel_clock_out = s_r.pclk;
  assign dev.flash_strobe    = s_r.flash;
  assign dev.pixel_bus       = s_r.pix;
  assign dev.pins_oe         = s_r.oe;
  assign analog_on           = s_r.ana;
  assign pll_on              = s_r.pll;
  assign clocks_gated        = s_r.gated;
  assign domain_clk_en       = s_r.dom;
  assign serial_ready        = s_r.ready;
endmodule : ssrc_dev

// File: rtl/ssrc_host.sv
/*
 host end: axi4-lite slave driving standby, reset, clock-run pins and
 sensor register accesses.
 assumes the sensor end sits on the same aclk.
*/
`timescale 1ns/1ps
module ssrc_host
  import ssrc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  ssrc_if.host             hif,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic        aw_got;
    logic [3:0]  aw_a;
    logic        w_got;
    logic [31:0] w_d;
    logic        bvalid;
    logic        rvalid;
    logic [31:0] rdata;
    logic        awready;
    logic        wready;
    logic        arready;
    logic [3:0]  ctrl;
    logic        pin;
    logic        clk_run;
    logic        stopped;
    logic [1:0]  scnt;
    logic [2:0]  wait_cnt;
    logic        req;
    logic        we;
    logic [7:0]  addr;
    logic [15:0] wd;
    logic [15:0] rd;
  } ssrc_host_type;

  ssrc_host_type s_r;
  ssrc_host_type s_nxt;
  logic          busy;

  always_comb begin
    s_nxt = s_r;
    busy  = s_r.req | (s_r.wait_cnt != 3'(HOST_WAIT_CYC));
    // ****************************************
    // axi4-lite write
    // ****************************************
    if (s_axi_awvalid && s_r.awready) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.aw_a   = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_r.wready) begin
      s_nxt.w_got = 1'b1;
      s_nxt.w_d   = s_axi_wdata;
    end
    if (s_r.aw_got && s_r.w_got) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got  = 1'b0;
      s_nxt.bvalid = 1'b1;
      if (s_r.aw_a == H_CTRL) begin
        s_nxt.ctrl = s_r.w_d[3:0];
      end else if (s_r.aw_a == H_ACC && s_r.w_d[A_GO] && !busy) begin
        s_nxt.req  = 1'b1;
        s_nxt.we   = s_r.w_d[A_WE];
        s_nxt.addr = s_r.w_d[23:16];
        s_nxt.wd   = s_r.w_d[15:0];
      end
    end
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    // ****************************************
    // axi4-lite read
    // ****************************************
    if (s_axi_arvalid && s_r.arready) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = '0;
      case (s_axi_araddr)
        H_CTRL:  s_nxt.rdata = {28'h000_0000, s_r.ctrl};
        H_STAT:  s_nxt.rdata = {11'h000, s_r.clk_run, s_r.pin, hif.frame_valid,
                                hif.line_valid, busy, s_r.rd};
        default: s_nxt.rdata = '0;
      endcase
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    // ****************************************
    // pins
    // ****************************************
    if (s_r.req && hif.ack) begin
      s_nxt.req = 1'b0;
      s_nxt.rd  = hif.rdata;
    end
    // reset pin follows its bit; default holds the sensor in reset
    // clock stop keeps the count: orders still queue for a frozen sensor
    if (!s_r.ctrl[C_HRST]) begin
      if (s_r.clk_run && s_r.wait_cnt != 3'(HOST_WAIT_CYC)) begin
        s_nxt.wait_cnt = s_r.wait_cnt + 3'd1;
      end
    end else begin
      s_nxt.wait_cnt = '0;
    end
    // pin may only fall once the clock ran the cycle before
    s_nxt.pin = s_r.ctrl[C_STBY] | (s_r.pin & ~s_r.clk_run);
    if (!s_r.ctrl[C_STBY]) begin
      s_nxt.stopped = 1'b0;
      s_nxt.scnt    = '0;
    end else if (s_r.ctrl[C_AUTO] && s_r.pin && !hif.frame_valid && !hif.line_valid) begin
      if (s_r.scnt == 2'(STOP_WAIT_CYC)) begin
        s_nxt.stopped = 1'b1;
      end else begin
        s_nxt.scnt = s_r.scnt + 2'd1;
      end
    end else if (!s_r.stopped) begin
      s_nxt.scnt = '0;
    end
    s_nxt.clk_run = s_r.ctrl[C_CLKON] & ~s_nxt.stopped;
    s_nxt.awready = ~s_nxt.aw_got & ~s_nxt.bvalid;
    s_nxt.wready  = ~s_nxt.w_got & ~s_nxt.bvalid;
    s_nxt.arready = ~s_nxt.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_r         <= '0;
      s_r.ctrl    <= CTRL_RST;
      s_r.awready <= 1'b1;
      s_r.wready  <= 1'b1;
      s_r.arready <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign hif.standby_pin = s_r.pin;
  assign hif.reset_pin_n = ~s_r.ctrl[C_HRST];
  assign hif.clk_run     = s_r.clk_run;
  assign hif.req         = s_r.req;
  assign hif.we          = s_r.we;
  assign hif.addr        = s_r.addr;
  assign hif.wdata       = s_r.wd;
  assign s_axi_awready   = s_r.awready;
  assign s_axi_wready    = s_r.wready;
  assign s_axi_bresp     = 2'b00;
  assign s_axi_bvalid    = s_r.bvalid;
  assign s_axi_arready   = s_r.arready;
  assign s_axi_rdata     = s_r.rdata;
  assign s_axi_rresp     = 2'b00;
  assign s_axi_rvalid    = s_r.rvalid;
endmodule : ssrc_host

// File: testbench/ssrc_monitor.sv
/*
 checker for the host / sensor pin interface.
 assumes both ends share aclk; instantiated by tb_top beside the interface.
*/
`timescale 1ns/1ps
module ssrc_monitor
  import ssrc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        standby_pin,
  input wire logic        reset_pin_n,
  input wire logic        clk_run,
  input wire logic        req,
  input wire logic        we,
  input wire logic [7:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        ack,
  input wire logic        line_valid,
  input wire logic        frame_valid,
  input wire logic        pixel_clock_out,
  input wire logic        flash_strobe,
  input wire logic [9:0]  pixel_bus
);
  // ****
  // helper state
  // ****
  logic       pin_dis_r;
  logic [5:0] stby_cnt_r;
  logic [3:0] up_cnt_r;
  logic       quiet;
  logic       valids_low;
  assign valids_low = !line_valid && !frame_valid;
  assign quiet = valids_low && !pixel_clock_out && !flash_strobe && pixel_bus == 10'h000;
  // mask tracked from acked writes; soft reset with the mask set is not modelled
  always_ff @(posedge aclk) begin
    if (!aresetn || !reset_pin_n) begin
      pin_dis_r <= 1'b0;
      up_cnt_r  <= 4'h0;
    end else begin
      if (ack && we && addr == SCR_ADDR) pin_dis_r <= wdata[SCR_PINDIS];
      if (up_cnt_r != 4'hF) up_cnt_r <= up_cnt_r + 4'h1;
    end
  end
  // a stopped clock freezes the sensor, so the count holds meanwhile
  always_ff @(posedge aclk) begin
    if (!aresetn || !standby_pin || pin_dis_r) stby_cnt_r <= 6'h00;
    else if (clk_run && stby_cnt_r != 6'h3F) stby_cnt_r <= stby_cnt_r + 6'h01;
  end
  // ****
  // assertions
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_ack_single: assert property (ack |=> !ack)
    else $error("ack held over one cycle");
  chk_ack_req: assert property (ack |-> req && $past(req))
    else $error("ack without request");
  chk_req_steady: assert property (req && !ack |=> req && $stable({we, addr, wdata}))
    else $error("request changed before ack");
  chk_ack_clock_on: assert property (ack |-> $past(clk_run))
    else $error("ack while input clock stopped");
  chk_standby_quiet: assert property (stby_cnt_r >= 6'h28 |-> quiet)
    else $error("video outputs active in standby");
  chk_wake_clock_first: assert property ($fell(standby_pin) |-> $past(clk_run))
    else $error("standby left with clock stopped");
  chk_reset_quiet: assert property (!reset_pin_n [*5] |-> quiet && !ack)
    else $error("outputs active in hard reset");
  chk_ready_delay: assert property (ack |-> up_cnt_r >= 4'h5)
    else $error("serial answer too soon after reset");
  chk_auto_stop: assert property ($fell(clk_run) && standby_pin |->
    $past(valids_low, 2) && $past(valids_low, 3))
    else $error("clock stopped while video valid");
  cover property (ack && we);
  cover property (ack && !we && standby_pin);
  cover property ($fell(clk_run) && standby_pin);
  cover property (stby_cnt_r == 6'h28);
endmodule : ssrc_monitor

// File: testbench/tb_top.sv
/*
 self-checking bench: axi4-lite master drives the host end, which drives the sensor end.
 assumes the package constants; both ends run on the one aclk.
*/
`timescale 1ns/1ps
module tb_top;
  import ssrc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, dom;
  logic [31:0] wdat, rdat;
  logic        analog_on, pll_on, clocks_gated, serial_ready;
  logic [13:0] video;
  int          miscompares, check_count;
  ssrc_if ssrc_if_i ();
  assign video = {ssrc_if_i.line_valid, ssrc_if_i.frame_valid, ssrc_if_i.pixel_clock_out,
                  ssrc_if_i.flash_strobe, ssrc_if_i.pixel_bus};
  ssrc_dev ssrc_dev_i (.aclk(aclk), .aresetn(aresetn), .dev(ssrc_if_i), .analog_on(analog_on),
    .pll_on(pll_on), .clocks_gated(clocks_gated), .domain_clk_en(dom),
    .serial_ready(serial_ready));
  ssrc_host ssrc_host_i (.aclk(aclk), .aresetn(aresetn), .hif(ssrc_if_i),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdat), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdat), .s_axi_rresp(),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  ssrc_monitor ssrc_monitor_i (.aclk(aclk), .aresetn(aresetn),
    .standby_pin(ssrc_if_i.standby_pin), .reset_pin_n(ssrc_if_i.reset_pin_n),
    .clk_run(ssrc_if_i.clk_run), .req(ssrc_if_i.req), .we(ssrc_if_i.we),
    .addr(ssrc_if_i.addr), .wdata(ssrc_if_i.wdata), .ack(ssrc_if_i.ack),
    .line_valid(ssrc_if_i.line_valid), .frame_valid(ssrc_if_i.frame_valid),
    .pixel_clock_out(ssrc_if_i.pixel_clock_out), .flash_strobe(ssrc_if_i.flash_strobe),
    .pixel_bus(ssrc_if_i.pixel_bus));
  // ****
  // bus cycles and compares
  // ****
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge aclk);
    awaddr  <= a;
    wdat    <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw_done = aw_done | awready;
      w_done = w_done | wready;
    end while (!(aw_done && w_done));
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
  endtask : axi_write
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdat;
    rready <= 1'b0;
  endtask : axi_read
  // waits out busy on both sides, so an order is never dropped
  task automatic acc(input logic w, input logic [7:0] r, input logic [15:0] d,
                     output logic [15:0] q);
    logic [31:0] s;
    s = 32'h0001_0000;
    while (s[16] !== 1'b0) axi_read(H_STAT, s);
    axi_write(H_ACC, {1'b1, w, 6'h00, r, d});
    s = 32'h0001_0000;
    while (s[16] !== 1'b0) axi_read(H_STAT, s);
    q = s[15:0];
  endtask : acc
  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word
  task automatic cmp_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_bit
  task automatic wait_gated(input logic v);
    for (int i = 0; i < 200 && clocks_gated !== v; i++) @(posedge aclk);
  endtask : wait_gated
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    logic [31:0] d;
    logic [15:0] q;
    axi_read(H_CTRL, d);
    cmp_word(d, 32'(CTRL_RST));
    cmp_bit(serial_ready, 1'b0);
    axi_write(H_CTRL, 32'h0000_0004);
    acc(1'b0, SCR_ADDR, 16'h0000, q);
    cmp_word(32'(q), 32'(SCR_RESET));
    cmp_bit(serial_ready, 1'b1);
    acc(1'b0, CPC_ADDR, 16'h0000, q);
    cmp_word(32'(q), 32'(CPC_RESET));
    axi_read(4'hC, d);
    cmp_word(d, 32'h0000_0000);
  endtask : t_reset
  task automatic t_pin;
    logic [15:0] q;
    acc(1'b1, CPC_ADDR, 16'hA000, q);
    axi_write(H_CTRL, 32'h0000_0005);
    wait_gated(1'b1);
    cmp_bit(clocks_gated, 1'b1);
    cmp_bit(analog_on, 1'b0);
    cmp_bit(pll_on, 1'b0);
    cmp_word(32'(video), 32'h0000_0000);
    cmp_bit(ssrc_if_i.pins_oe, 1'b0);
    acc(1'b1, CPC_ADDR, 16'hA00F, q);
    acc(1'b0, CPC_ADDR, 16'h0000, q);
    cmp_word(32'(q), 32'h0000_A00F);
    cmp_word(32'(dom), 32'h0000_000F);
    cmp_bit(clocks_gated, 1'b1);
    axi_write(H_CTRL, 32'h0000_0004);
    wait_gated(1'b0);
    cmp_bit(analog_on, 1'b0);
    repeat (WAKE_ANA_CYC + 1) @(posedge aclk);
    cmp_bit(analog_on, 1'b1);
    cmp_bit(pll_on, 1'b1);
    acc(1'b1, CPC_ADDR, CPC_RESET, q);
  endtask : t_pin
  task automatic t_soft_standby;
    logic [15:0] q;
    acc(1'b1, CPC_ADDR, 16'h0000, q);
    acc(1'b1, SCR_ADDR, 16'h0080, q);
    axi_write(H_CTRL, 32'h0000_0005);
    repeat (60) @(posedge aclk);
    cmp_bit(clocks_gated, 1'b0);
    acc(1'b1, SCR_ADDR, 16'h0084, q);
    wait_gated(1'b1);
    cmp_bit(clocks_gated, 1'b1);
    cmp_bit(pll_on, 1'b1);
    axi_write(H_CTRL, 32'h0000_0004);
    repeat (10) @(posedge aclk);
    cmp_bit(clocks_gated, 1'b1);
    acc(1'b1, SCR_ADDR, 16'h0000, q);
    wait_gated(1'b0);
    cmp_bit(clocks_gated, 1'b0);
    acc(1'b1, CPC_ADDR, CPC_RESET, q);
  endtask : t_soft_standby
  // request withdrawn a few cycles after it was raised
  task automatic t_latch;
    axi_write(H_CTRL, 32'h0000_0005);
    axi_write(H_CTRL, 32'h0000_0004);
    wait_gated(1'b1);
    cmp_bit(clocks_gated, 1'b1);
    wait_gated(1'b0);
    cmp_bit(clocks_gated, 1'b0);
  endtask : t_latch
  task automatic t_clock_stop;
    logic [31:0] d;
    axi_write(H_CTRL, 32'h0000_000D);
    for (int i = 0; i < 300 && ssrc_if_i.clk_run !== 1'b0; i++) @(posedge aclk);
    cmp_bit(ssrc_if_i.clk_run, 1'b0);
    axi_write(H_ACC, {2'b10, 6'h00, SCR_ADDR, 16'h0000});
    repeat (20) @(posedge aclk);
    axi_read(H_STAT, d);
    cmp_bit(d[16], 1'b1);
    // dropping the request restarts the clock before the pin falls
    axi_write(H_CTRL, 32'h0000_0004);
    do axi_read(H_STAT, d); while (d[16] !== 1'b0);
    cmp_word(32'(d[15:0]), 32'h0000_0000);
    axi_write(H_CTRL, 32'h0000_0004);
    wait_gated(1'b0);
    cmp_bit(clocks_gated, 1'b0);
  endtask : t_clock_stop
  task automatic t_resets;
    logic [15:0] q;
    acc(1'b1, CPC_ADDR, 16'h800F, q);
    acc(1'b1, SCR_ADDR, 16'h0001, q);
    acc(1'b0, CPC_ADDR, 16'h0000, q);
    cmp_word(32'(q), 32'(CPC_RESET));
    acc(1'b1, SCR_ADDR, 16'h0040, q);
    acc(1'b0, SCR_ADDR, 16'h0000, q);
    cmp_word(32'(q), 32'h0000_0040);
    acc(1'b1, CPC_ADDR, 16'h800F, q);
    cmp_word(32'(dom), 32'h0000_000F);
    axi_write(H_CTRL, 32'h0000_0002);
    repeat (10) @(posedge aclk);
    cmp_bit(serial_ready, 1'b0);
    axi_write(H_CTRL, 32'h0000_0004);
    acc(1'b0, CPC_ADDR, 16'h0000, q);
    cmp_word(32'(q), 32'(CPC_RESET));
  endtask : t_resets
  task automatic summarize;
    if (miscompares == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : summarize
  // ****
  // clock, reset, sequence, watchdog
  // ****
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdat = 32'h0000_0000;
    miscompares = 0;
    check_count = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_pin;
    t_soft_standby;
    t_latch;
    t_clock_stop;
    t_resets;
    summarize;
  end
  initial begin
    #3000000;
    miscompares++;
    summarize;
  end
endmodule : tb_top
